// *** hdl/synth_if_feedback_word_decode.sv ***
// Purpose: shifts in the three-wire programming words and decodes them
// Assumes: serial clock, data and latch enable are asynchronous pins,
//          serial clock well below clk/4 so every edge is seen
// Notes:   the last 22 bits before the latch edge form the word
`timescale 1ns/1ps
`include "synth_if_defs.svh"

module synth_if_feedback_word_decode (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       ser_clk,          // serial clock pin
  input  wire logic                       ser_data,         // serial data pin
  input  wire logic                       latch_enable,     // word latch pin
  input  wire logic                       if_divider_wrap,  // feedback divider terminal count pulse
  output synth_if_pkg::if_feedback_t      if_cfg,           // decoded feedback word
  output synth_if_pkg::rf_reference_t     rf_cfg,           // decoded rf reference word
  output logic                            if_pump_float,    // if pump output high impedance
  output logic                            if_power_down     // effective if loop powerdown
);

  // synchronised pins: {latch_enable, ser_data, ser_clk}
  logic [`PIN_COUNT-1:0]          pin_s;
  logic [`PIN_COUNT-1:0]          pin_prev_r;   // last seen synced levels
  logic [`PIN_COUNT-1:0]          pin_prev_nxt;
  logic                           clk_rise;     // serial clock rising edge
  logic                           le_rise;      // latch enable rising edge
  logic [`WORD_W-1:0]             shift_r;      // serial shift register
  logic [`WORD_W-1:0]             shift_nxt;
  logic [`ADDR_W-1:0]             addr;         // address field of held word
  logic                           load_if_fb;   // latch of a feedback word
  logic                           load_rf_ref;  // latch of an rf reference word
  logic                           load_if_ref;  // latch of an if reference word
  synth_if_pkg::if_feedback_t     if_cfg_r;
  synth_if_pkg::if_feedback_t     if_cfg_nxt;
  synth_if_pkg::rf_reference_t    rf_cfg_r;
  synth_if_pkg::rf_reference_t    rf_cfg_nxt;
  logic                           float_r;      // if pump float bit
  logic                           float_nxt;
  logic                           pd_r;         // effective powerdown
  logic                           pd_nxt;

  // pins cross into clk before anything looks at them
  pin_sync #(
    .WIDTH   (`PIN_COUNT)
  ) u_pin_sync (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .pin_in  ({latch_enable, ser_data, ser_clk}),
    .pin_out (pin_s)
  );

  // edge detection on the synchronised levels
  assign clk_rise    = ce && pin_s[0] && !pin_prev_r[0];
  assign le_rise     = ce && pin_s[2] && !pin_prev_r[2];
  assign addr        = shift_r[`ADDR_W-1:0];
  // address decode of the completed word
  assign load_if_fb  = le_rise && (addr == `ADDR_IF_FB);
  assign load_rf_ref = le_rise && (addr == `ADDR_RF_REF);
  assign load_if_ref = le_rise && (addr == `ADDR_IF_REF);

  // shifter: msb first, so the newest bit lands in bit 0
  always_comb begin
    pin_prev_nxt = pin_prev_r;
    shift_nxt    = shift_r;
    if (rst) begin
      pin_prev_nxt = '0;
      shift_nxt    = '0;
    end else if (ce) begin
      pin_prev_nxt = pin_s;
      // a latch edge in the same cycle uses the word before this bit
      if (clk_rise) begin
        shift_nxt = {shift_r[`WORD_W-2:0], pin_s[1]};
      end
    end
  end

  always_ff @(posedge clk) begin
    pin_prev_r <= pin_prev_nxt;
    shift_r    <= shift_nxt;
  end

  // word decode into the held configuration
  always_comb begin
    if_cfg_nxt = if_cfg_r;
    rf_cfg_nxt = rf_cfg_r;
    float_nxt  = float_r;
    if (rst) begin
      if_cfg_nxt.power_down     = `BIT_RST;
      if_cfg_nxt.prescale_sel   = `BIT_RST;
      if_cfg_nxt.binary_count   = `BINARY_RST;
      if_cfg_nxt.swallow_count  = `SWALLOW_RST;
      rf_cfg_nxt.lock_output_select = `LOCK_SEL_RST;
      rf_cfg_nxt.pump_float         = `BIT_RST;
      rf_cfg_nxt.pump_gain          = `BIT_RST;
      rf_cfg_nxt.detector_polarity  = `BIT_RST;
      rf_cfg_nxt.reference_divide   = `RDIV_RST;
      float_nxt                     = `BIT_RST;
    end else begin
      if (load_if_fb) begin
        // only the low four swallow bits are kept; the rest are don't care
        if_cfg_nxt.swallow_count = shift_r[`SWALLOW_LSB +: `SWALLOW_USED];
        // no range check: values below 3 are the host's to avoid
        if_cfg_nxt.binary_count  = shift_r[`BINARY_LSB +: `BINARY_W];
        if_cfg_nxt.prescale_sel  = shift_r[`PRESCALE_BIT];
        if_cfg_nxt.power_down    = shift_r[`PWDN_BIT];
      end
      if (load_rf_ref) begin
        rf_cfg_nxt.reference_divide   = shift_r[`RF_RDIV_LSB +: `RF_RDIV_W];
        rf_cfg_nxt.detector_polarity  = shift_r[`RF_POL_BIT];
        rf_cfg_nxt.pump_gain          = shift_r[`RF_GAIN_BIT];
        rf_cfg_nxt.pump_float         = shift_r[`RF_FLOAT_BIT];
        rf_cfg_nxt.lock_output_select = shift_r[`LOCK_SEL_LSB +: `LOCK_SEL_W];
      end
      // float takes effect on the latch itself, not on a divider event
      if (load_if_ref) begin
        float_nxt = shift_r[`IF_FLOAT_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if_cfg_r <= if_cfg_nxt;
    rf_cfg_r <= rf_cfg_nxt;
    float_r  <= float_nxt;
  end

  // effective powerdown: float set means asynchronous, so it follows the
  // request at once; float clear waits for the divider to wrap so the
  // loop stops cleanly; powering up is never delayed
  always_comb begin
    pd_nxt = pd_r;
    if (rst) begin
      pd_nxt = `BIT_RST;
    end else if (ce) begin
      if (!if_cfg_nxt.power_down) begin
        pd_nxt = 1'h0;
      end else if (float_nxt) begin
        pd_nxt = 1'h1;
      end else if (if_divider_wrap) begin
        pd_nxt = 1'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    pd_r <= pd_nxt;
  end

  assign if_cfg        = if_cfg_r;
  assign rf_cfg        = rf_cfg_r;
  assign if_pump_float = float_r;
  assign if_power_down = pd_r;

  // ---------------- assertions ----------------

  sequence s_async_down;
    load_if_fb && shift_r[`PWDN_BIT] && float_r;
  endsequence

  sequence s_sync_wait;
    ce && if_cfg_r.power_down && !float_r && !pd_r && !if_divider_wrap && !le_rise;
  endsequence

  a_swallow_hold: assert property (@(posedge clk) disable iff (rst)
    !load_if_fb |=> $stable(if_cfg_r.swallow_count))
    else $error("swallow count changed without a feedback word");

  a_swallow_low: assert property (@(posedge clk) disable iff (rst)
    load_if_fb |=> if_cfg_r.swallow_count == $past(shift_r[5:2]))
    else $error("swallow count not taken from word bits 5..2");

  a_binary_field: assert property (@(posedge clk) disable iff (rst)
    load_if_fb |=> if_cfg_r.binary_count == $past(shift_r[19:9]))
    else $error("binary count not taken from word bits 19..9");

  a_prescale_bit: assert property (@(posedge clk) disable iff (rst)
    load_if_fb |=> if_cfg_r.prescale_sel == $past(shift_r[20]))
    else $error("prescaler select not taken from bit 20");

  a_power_up: assert property (@(posedge clk) disable iff (rst)
    load_if_fb && !shift_r[21] |=> !pd_r)
    else $error("powerup not immediate");

  a_async_down: assert property (@(posedge clk) disable iff (rst)
    s_async_down |=> pd_r)
    else $error("asynchronous powerdown did not apply at once");

  a_sync_wait: assert property (@(posedge clk) disable iff (rst)
    s_sync_wait |=> !pd_r)
    else $error("synchronous powerdown did not wait for divider wrap");

  a_rf_fields: assert property (@(posedge clk) disable iff (rst)
    load_rf_ref |=> rf_cfg_r == $past(shift_r[21:2]))
    else $error("rf reference fields mismatch");

  a_float_now: assert property (@(posedge clk) disable iff (rst)
    load_if_ref |=> float_r == $past(shift_r[19]))
    else $error("pump float not applied on the latch");

  a_addr_ignore: assert property (@(posedge clk) disable iff (rst)
    le_rise && addr == 2'h3 |=> $stable(if_cfg_r) && $stable(rf_cfg_r) && $stable(float_r))
    else $error("unused address changed decoded state");

endmodule // synth_if_feedback_word_decode

// *** shared/synth_if_defs.svh ***
// Purpose: constants for the serial programming word decoder
// Assumes: 22-bit words shifted in msb first, address in the two lsbs
// Notes:   every field position and reset value lives here as a macro
`ifndef SYNTH_IF_DEFS_SVH
`define SYNTH_IF_DEFS_SVH

// word geometry
`define WORD_W         22
`define ADDR_W         2

// address codes in word bits [1:0]
`define ADDR_IF_REF    2'h0
`define ADDR_IF_FB     2'h1
`define ADDR_RF_REF    2'h2

// if feedback word fields
`define SWALLOW_LSB    2
`define SWALLOW_W      7
`define SWALLOW_USED   4
`define BINARY_LSB     9
`define BINARY_W       11
`define PRESCALE_BIT   20
`define PWDN_BIT       21

// if reference word: only the pump float bit is decoded here
`define IF_FLOAT_BIT   19

// rf reference word fields
`define RF_RDIV_LSB    2
`define RF_RDIV_W      15
`define RF_POL_BIT     17
`define RF_GAIN_BIT    18
`define RF_FLOAT_BIT   19
`define LOCK_SEL_LSB   20
`define LOCK_SEL_W     2

// reset values of the decoded fields
`define SWALLOW_RST    4'h0
`define BINARY_RST     11'h000
`define RDIV_RST       15'h0000
`define LOCK_SEL_RST   2'h0
`define BIT_RST        1'h0

// synchroniser depth and pin count
`define SYNC_STAGES    2
`define PIN_COUNT      3

`endif

// *** shared/synth_if_pkg.sv ***
// Purpose: packed carriers for the decoded programming words
// Assumes: field widths come from synth_if_defs.svh
// Notes:   msb-first field order matches the word layout
`include "synth_if_defs.svh"

package synth_if_pkg;

  // decoded if feedback divider word
  typedef struct packed {
    logic                          power_down;     // requested powerdown
    logic                          prescale_sel;   // 0: 8/9, 1: 16/17
    logic [`BINARY_W-1:0]          binary_count;   // b count
    logic [`SWALLOW_USED-1:0]      swallow_count;  // a count, 0..15
  } if_feedback_t;

  // decoded rf reference divider word
  typedef struct packed {
    logic [`LOCK_SEL_W-1:0]        lock_output_select;
    logic                          pump_float;
    logic                          pump_gain;
    logic                          detector_polarity;
    logic [`RF_RDIV_W-1:0]         reference_divide;
  } rf_reference_t;

endpackage

// *** hdl/pin_sync.sv ***
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level; no bus coherence needed
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`include "synth_if_defs.svh"

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_r;   // first stage, may go metastable
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;   // second stage, safe to read
  logic [WIDTH-1:0] sync_nxt;

  // refused while elaborating: a zero-width group has no stages to build
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  // next values: shift one stage per enabled clock
  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (rst) begin
      meta_nxt = '0;
      sync_nxt = '0;
    end else if (ce) begin
      meta_nxt = pin_in;
      sync_nxt = meta_r;
    end
  end

  // register only
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign pin_out = sync_r;

endmodule // pin_sync

// *** dv/serial_host.sv ***
// Purpose: host model that loads words over the three-wire serial link
// Assumes: pins move just after clk edges; the block samples them as async pins
// Notes:   serial clock stands still low between words
`timescale 1ns/1ps
`include "synth_if_defs.svh"

module serial_host (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      latch_enable
);
  // pins idle low before the first word
  initial begin
    ser_clk      = 1'h0;
    ser_data     = 1'h0;
    latch_enable = 1'h0;
  end

  // shift one word msb first, then pulse the latch
  task automatic send(input logic [`WORD_W-1:0] word);
    for (int i = `WORD_W - 1; i >= 0; i--) begin
      ser_data <= word[i];
      ser_clk  <= 1'h0;
      repeat (6) @(posedge clk);
      ser_clk <= 1'h1;
      // 6 or 7 cycles high, so the bit period averages 125 ns
      repeat (6 + (i % 2)) @(posedge clk);
    end
    ser_clk  <= 1'h0;
    // released data line shows the inverse, never a held last bit
    ser_data <= ~word[0];
    // latch well clear of the last serial edge
    repeat (4) @(posedge clk);
    latch_enable <= 1'h1;
    repeat (4) @(posedge clk);
    latch_enable <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
endmodule // serial_host

// *** dv/synth_if_feedback_word_decode_tb_top.sv ***
// Purpose: self-checking bench for the programming word decoder
// Assumes: ce high except in the freeze test; host shifts whole 22-bit words
// Notes:   each check waits until the latched word has settled
`timescale 1ns/1ps

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module synth_if_feedback_word_decode_tb_top;
  logic                        clk;             // 100 MHz
  logic                        rst;             // sync reset
  logic                        ce;              // clock enable
  logic                        ser_clk;         // from host
  logic                        ser_data;        // from host
  logic                        latch_enable;    // from host
  logic                        if_divider_wrap; // divider wrap pulse
  synth_if_pkg::if_feedback_t  if_cfg;          // decoded feedback word
  synth_if_pkg::rf_reference_t rf_cfg;          // decoded rf word
  logic                        if_pump_float;   // pump float
  logic                        if_power_down;   // effective powerdown
  int                          bad_count;       // mismatches
  int                          comparisons;     // checks made

  serial_host i_host (
    .clk          (clk),
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .latch_enable (latch_enable)
  );

  synth_if_feedback_word_decode i_dut (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .ser_clk         (ser_clk),
    .ser_data        (ser_data),
    .latch_enable    (latch_enable),
    .if_divider_wrap (if_divider_wrap),
    .if_cfg          (if_cfg),
    .rf_cfg          (rf_cfg),
    .if_pump_float   (if_pump_float),
    .if_power_down   (if_power_down)
  );

  // free-running clock
  always #5 clk = ~clk;

  // feedback word: powerdown, prescaler, b count, 7-bit a field, address 01
  function automatic logic [21:0] fb(logic pd, logic pre, logic [10:0] b, logic [6:0] a);
    return {pd, pre, b, a, 2'h1};
  endfunction

  // if reference word: only the pump float bit matters here, address 00
  function automatic logic [21:0] ifr(logic fl);
    return {2'h0, fl, 17'h00000, 2'h0};
  endfunction

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: tests need about 32 us
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    clk             = 1'h0;
    rst             = 1'h1;
    ce              = 1'h1;
    if_divider_wrap = 1'h0;
    bad_count       = 0;
    comparisons     = 0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK(if_power_down, 1'h0)
    `CHK(if_pump_float, 1'h0)
    end_test("reset");
    // top b count, swallow upper bits set but ignored
    i_host.send(fb(1'h0, 1'h1, 11'h7FF, 7'h75));
    `CHK(if_cfg, {1'h0, 1'h1, 11'h7FF, 4'h5})
    // lowest b count, top swallow count, other prescaler
    i_host.send(fb(1'h0, 1'h0, 11'h003, 7'h0F));
    `CHK(if_cfg, {1'h0, 1'h0, 11'h003, 4'hF})
    end_test("feedback");
    // rf word leaves the feedback fields alone
    i_host.send({2'h3, 1'h1, 1'h0, 1'h1, 15'h4D2B, 2'h2});
    `CHK(rf_cfg, {2'h3, 1'h1, 1'h0, 1'h1, 15'h4D2B})
    `CHK(if_cfg, {1'h0, 1'h0, 11'h003, 4'hF})
    // address 11 changes nothing
    i_host.send(22'h3FFFFF);
    `CHK(rf_cfg, {2'h3, 1'h1, 1'h0, 1'h1, 15'h4D2B})
    `CHK(if_cfg, {1'h0, 1'h0, 11'h003, 4'hF})
    end_test("address");
    // float set: powerdown acts at once
    i_host.send(ifr(1'h1));
    `CHK(if_pump_float, 1'h1)
    i_host.send(fb(1'h1, 1'h0, 11'h003, 7'h00));
    `CHK(if_power_down, 1'h1)
    i_host.send(fb(1'h0, 1'h0, 11'h003, 7'h00));
    `CHK(if_power_down, 1'h0)
    end_test("async_powerdown");
    // float clear: powerdown waits for a divider wrap
    i_host.send(ifr(1'h0));
    `CHK(if_pump_float, 1'h0)
    i_host.send(fb(1'h1, 1'h0, 11'h003, 7'h00));
    `CHK(if_cfg.power_down, 1'h1)
    repeat (20) @(posedge clk);
    `CHK(if_power_down, 1'h0)
    if_divider_wrap <= 1'h1;
    @(posedge clk);
    if_divider_wrap <= 1'h0;
    @(posedge clk);
    `CHK(if_power_down, 1'h1)
    i_host.send(fb(1'h0, 1'h0, 11'h003, 7'h00));
    `CHK(if_power_down, 1'h0)
    end_test("sync_powerdown");
    // ce low freezes the block, so a whole word goes unseen
    ce <= 1'h0;
    i_host.send(fb(1'h1, 1'h1, 11'h7FF, 7'h0F));
    ce <= 1'h1;
    repeat (4) @(posedge clk);
    `CHK(if_cfg, {1'h0, 1'h0, 11'h003, 4'h0})
    `CHK(if_power_down, 1'h0)
    end_test("clock_enable");
    complete_run();
  end
endmodule // synth_if_feedback_word_decode_tb_top
